/* File: card_model.sv */
// Purpose: Card side stand-in for the detect pin and card clock
// Assumes: Detect pin high while a card sits in the slot
// Notes:   Count only grows; the bench takes differences
`timescale 1ns/1ps
module card_model (
    input  wire logic card_clock,
    input  wire logic inserted,
    output logic      card_detect_pin,
    output int        rises
);
    initial rises = 0;
    assign card_detect_pin = inserted;
    always @(posedge card_clock) rises <= rises + 1;
endmodule

/* File: regs_properties.sv */
// Purpose: Port timing checks for the register bank
// Assumes: One clock; the bench leaves gaps between writes
// Notes:   Attached by bind at the foot of this file
`timescale 1ns/1ps
module regs_properties
    import sdhc_regs_pkg::*;
(
    input wire logic                             clk,
    input wire logic                             reset_n,
    input wire logic [sdhc_regs_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0]                      wdata,
    input wire logic                             wr_stb,
    input wire logic                             rd_stb,
    input wire logic [31:0]                      rdata,
    input wire logic                             continue_request,
    input wire logic                             stop_at_gap_request,
    input wire logic                             card_present,
    input wire logic                             descriptor_dma_v2,
    input wire logic                             soft_reset_data_path,
    input wire logic                             soft_reset_cmd_path,
    input wire logic                             soft_reset_full,
    input wire logic [4:0]                       timeout_exponent,
    input wire logic                             card_clock
);
    // ==========================================
    // Write sequences
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_wr_one;
        wr_stb && addr == OFS_CTRL_ONE;
    endsequence
    sequence s_wr_two;
        wr_stb && addr == OFS_CTRL_TWO;
    endsequence
    // ==========================================
    // Checks
    a_continue_pulse: assert property (s_wr_one ##0 wdata[17] && !stop_at_gap_request
        |=> continue_request) else $error("continue pulse missing");
    a_continue_blocked: assert property (s_wr_one ##0 stop_at_gap_request
        |=> !continue_request) else $error("continue not blocked by stop");
    a_reset_pulses: assert property (s_wr_two
        |=> {soft_reset_data_path, soft_reset_cmd_path, soft_reset_full} == $past(wdata[26:24]))
        else $error("soft reset pulses wrong");
    a_timeout_exp: assert property (s_wr_two ##0 !wdata[24] ##1 !wr_stb
        |=> timeout_exponent == 5'd13 + $past(wdata[19:16], 2)) else $error("timeout exponent");
    a_status_summary: assert property (rd_stb && addr == OFS_EVENT_STATUS
        |=> rdata[15] == |rdata[9:0]) else $error("summary flag wrong");
    a_card_test_lvl: assert property (s_wr_one ##0 wdata[7:6] == 2'b11 ##1 !wr_stb [*2]
        |-> card_present) else $error("test level not used");
    a_dma_v2: assert property (s_wr_one ##0 wdata[4:3] == DMA_MODE_DESCRIPTOR_DMA_V2 ##1 !wr_stb [*2]
        |-> descriptor_dma_v2) else $error("dma mode decode wrong");
    a_clock_off: assert property (s_wr_two ##0 !wdata[2] ##1 !wr_stb [*2]
        |-> !card_clock) else $error("card clock runs while disabled");
endmodule
bind sd_host_control_status_regs regs_properties chk (.*);

/* File: sd_host_control_status_regs.sv */
// Purpose: Control and event flag register bank of a card host controller
// Assumes: Single 100 MHz clock; card detect pin is asynchronous
// Notes:   Flags clear on write-one; a hardware set wins over a same-cycle clear
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module sd_host_control_status_regs
    import sdhc_regs_pkg::*;
(
    input  wire logic                            clk,
    input  wire logic                            reset_n,
    input  wire logic [sdhc_regs_pkg::ADDR_W-1:0] addr,
    input  wire logic [31:0]                     wdata,
    input  wire logic                            wr_stb,
    input  wire logic                            rd_stb,
    output logic      [31:0]                     rdata,
    input  wire logic                            card_detect_pin,
    input  wire logic [15:0]                     event_set,
    input  wire logic [9:0]                      error_set,
    output logic                                 wake_on_removal,
    output logic                                 wake_on_insertion,
    output logic                                 wake_on_card_irq,
    output logic                                 irq_at_block_gap,
    output logic                                 read_wait_ctrl,
    output logic                                 continue_request,
    output logic                                 stop_at_gap_request,
    output logic                                 card_bus_power,
    output logic                                 card_present,
    output logic                                 descriptor_dma_v2,
    output logic                                 high_speed_enable,
    output logic                                 data_bus_width,
    output logic                                 soft_reset_data_path,
    output logic                                 soft_reset_cmd_path,
    output logic                                 soft_reset_full,
    output logic      [4:0]                      timeout_exponent,
    output logic                                 card_clock
);
    import sdhc_regs_pkg::*;

    // ==============================================================
    // State
    typedef struct packed {
        logic [31:0] ctrl_one;
        logic [31:0] ctrl_two;
        logic [31:0] status;
        logic [31:0] rdata;
        logic        cont_pulse;
        logic        rst_data;
        logic        rst_cmd;
        logic        rst_all;
        logic [2:0]  cd_sync;
        logic        cd_level;
        logic        present;
        logic [7:0]  settle_cnt;
        logic        stable;
        logic [7:0]  div_cnt;
        logic        clk_phase;
        logic        card_clk;
        logic        bypass;
        logic [4:0]  tmo_exp;
        logic        dma_v2;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic        wr_one;
    logic        wr_two;
    logic        wr_stat;
    logic [31:0] c1_w;
    logic [31:0] c2_w;
    logic [8:0]  half_div;
    logic [31:0] ev_in;

    // ==============================================================
    // Next state
    always_comb begin
        st_nxt  = st_r;
        wr_one  = wr_stb && (addr == OFS_CTRL_ONE);
        wr_two  = wr_stb && (addr == OFS_CTRL_TWO);
        wr_stat = wr_stb && (addr == OFS_EVENT_STATUS);
        c1_w    = wdata & C1_WRITE_MASK;
        c2_w    = wdata & C2_WRITE_MASK;
        ev_in   = {6'h00, error_set, 7'h00, event_set[8:0]};
        half_div = 9'h001;

        // Card detect pin: three stages, change accepted when last two agree
        st_nxt.cd_sync = {st_r.cd_sync[1:0], card_detect_pin};
        if (st_r.cd_sync[2] == st_r.cd_sync[1]) begin
            st_nxt.cd_level = st_r.cd_sync[2];
        end
        st_nxt.present = st_r.ctrl_one[C1_CD_SEL] ? st_r.ctrl_one[C1_CD_TEST]
                                                  : st_r.cd_level;

        // Control one
        st_nxt.cont_pulse = 1'b0;
        if (wr_one) begin
            st_nxt.ctrl_one = c1_w & ~(32'h1 << C1_CONTINUE);
            // Continue is a one-shot, refused while a stop is requested
            st_nxt.cont_pulse = wdata[C1_CONTINUE]
                                && !st_r.ctrl_one[C1_STOP_GAP];
        end

        // Control two; reset bits act as one-cycle pulses then self-clear
        st_nxt.rst_data = 1'b0;
        st_nxt.rst_cmd  = 1'b0;
        st_nxt.rst_all  = 1'b0;
        st_nxt.ctrl_two[C2_RST_ALL]  = 1'b0;
        st_nxt.ctrl_two[C2_RST_CMD]  = 1'b0;
        st_nxt.ctrl_two[C2_RST_DATA] = 1'b0;
        if (wr_two) begin
            st_nxt.ctrl_two = c2_w;
            st_nxt.rst_data = wdata[C2_RST_DATA];
            st_nxt.rst_cmd  = wdata[C2_RST_CMD];
            st_nxt.rst_all  = wdata[C2_RST_ALL];
        end
        st_nxt.tmo_exp = 5'(TIMEOUT_BASE_EXP)
                         + {1'b0, st_r.ctrl_two[C2_TIMEOUT_LO +: 4]};

        // Internal clock settle counter
        if (!st_r.ctrl_two[C2_INT_CLK_EN]) begin
            st_nxt.settle_cnt = SETTLE_CNT_INIT;
            st_nxt.stable     = 1'b0;
        end else if (st_r.settle_cnt != 8'h00) begin
            st_nxt.settle_cnt = st_r.settle_cnt - 8'h01;
        end else begin
            st_nxt.stable = 1'b1;
        end

        // Card clock divider: one-hot code n gives divide by 2n
        for (int i = 0; i < 8; i++) begin
            if (st_r.ctrl_two[C2_DIV_LO + i]) begin
                half_div = 9'(1 << i);
            end
        end
        st_nxt.bypass = (st_r.ctrl_two[C2_DIV_LO +: 8] == 8'h00);
        if (!st_r.stable || !st_r.ctrl_two[C2_CARD_CLK_EN]) begin
            // Held low while off; the bank relies on software ordering
            st_nxt.div_cnt   = 8'h00;
            st_nxt.clk_phase = 1'b0;
            st_nxt.card_clk  = 1'b0;
        end else if (st_r.bypass) begin
            // Base clock rate is not reachable from a flip-flop; toggle each edge
            st_nxt.clk_phase = ~st_r.clk_phase;
            st_nxt.card_clk  = ~st_r.clk_phase;
        end else if ({1'b0, st_r.div_cnt} + 9'h001 >= half_div) begin
            st_nxt.div_cnt   = 8'h00;
            st_nxt.clk_phase = ~st_r.clk_phase;
            st_nxt.card_clk  = ~st_r.clk_phase;
        end else begin
            st_nxt.div_cnt = st_r.div_cnt + 8'h01;
        end

        // Event flags: write-one clears, set from hardware wins
        if (wr_stat) begin
            st_nxt.status = st_r.status & ~(wdata & ST_FLAG_MASK);
        end
        st_nxt.status = (st_nxt.status & ST_FLAG_MASK)
                        | (ev_in & ST_FLAG_MASK);
        if (st_r.rst_cmd || st_r.rst_all) begin
            st_nxt.status = ev_in & ST_FLAG_MASK;
        end
        st_nxt.status[ST_SUMMARY] = |(st_nxt.status & ST_SUMMARY_SRC);

        if (st_r.rst_all) begin
            st_nxt.ctrl_one = RESET_VALUE;
            st_nxt.ctrl_two = RESET_VALUE;
        end

        // Decoded from the next value so the output tracks the field with no lag
        st_nxt.dma_v2 = (st_nxt.ctrl_one[C1_DMA_LO +: 2] == DMA_MODE_DESCRIPTOR_DMA_V2);

        // Read data: one cycle after the strobe, zero otherwise
        st_nxt.rdata = 32'h0000_0000;
        if (rd_stb) begin
            case (addr)
                OFS_CTRL_ONE:     st_nxt.rdata = st_r.ctrl_one;
                OFS_CTRL_TWO:     st_nxt.rdata = st_r.ctrl_two
                                                 | ({31'h0, st_r.stable} << C2_CLK_STABLE);
                OFS_EVENT_STATUS: st_nxt.rdata = st_r.status;
                default:          st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ==============================================================
    // Registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==============================================================
    // Outputs
    assign rdata                = st_r.rdata;
    assign wake_on_removal      = st_r.ctrl_one[C1_WAKE_REM];
    assign wake_on_insertion    = st_r.ctrl_one[C1_WAKE_INS];
    assign wake_on_card_irq     = st_r.ctrl_one[C1_WAKE_IRQ];
    assign irq_at_block_gap     = st_r.ctrl_one[C1_IRQ_GAP];
    assign read_wait_ctrl       = st_r.ctrl_one[C1_READ_WAIT];
    assign continue_request     = st_r.cont_pulse;
    assign stop_at_gap_request  = st_r.ctrl_one[C1_STOP_GAP];
    assign card_bus_power       = st_r.ctrl_one[C1_BUS_POWER];
    assign card_present         = st_r.present;
    assign descriptor_dma_v2    = st_r.dma_v2;
    assign high_speed_enable    = st_r.ctrl_one[C1_HIGH_SPEED];
    assign data_bus_width       = st_r.ctrl_one[C1_BUS_WIDTH];
    assign soft_reset_data_path = st_r.rst_data;
    assign soft_reset_cmd_path  = st_r.rst_cmd;
    assign soft_reset_full      = st_r.rst_all;
    assign timeout_exponent     = st_r.tmo_exp;
    assign card_clock           = st_r.card_clk;
endmodule

/* File: sd_host_control_status_regs_tb.sv */
// Purpose: Self-checking bench for the register bank
// Assumes: Card model on the detect pin and the card clock
// Notes:   Reads are queued by the driver and checked by the monitor
`timescale 1ns/1ps
module sd_host_control_status_regs_tb;
    import sdhc_regs_pkg::*;
    logic              clk = 0, reset_n = 0, wr_stb = 0, rd_stb = 0, inserted = 1, rd_d = 0;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0]       wdata = '0, rdata, d, st;
    logic [15:0]       event_set = '0;
    logic [9:0]        error_set = '0;
    logic [4:0]        timeout_exponent;
    logic              wake_on_removal, wake_on_insertion, wake_on_card_irq, irq_at_block_gap;
    logic              read_wait_ctrl, continue_request, stop_at_gap_request, card_bus_power;
    logic              card_present, descriptor_dma_v2, high_speed_enable, data_bus_width;
    logic              soft_reset_data_path, soft_reset_cmd_path, soft_reset_full;
    logic              card_clock, card_detect_pin;
    logic [31:0]       q[$];
    int                fail_count = 0, comparisons = 0, cycles = 0, rises, r0;
    sd_host_control_status_regs dut (.*);
    card_model card (.*);
    always #5 clk = ~clk;
    task automatic check_port(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_read(input logic [31:0] e, input logic [31:0] g);
        check_port("read data", e, g);
    endtask
    task automatic complete_run();
        $display("Mismatches %0d in %0d comparisons", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr_stb <= 1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr_stb <= 0;
    endtask
    // Expected value is queued before the strobe goes out
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        q.push_back(e);
        rd_stb <= 1;
        addr <= a;
        @(posedge clk);
        rd_stb <= 0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // ==========================================
    // Monitor and hang guard
    always @(posedge clk) begin
        rd_d <= rd_stb;
        if (rd_d) check_read(q.pop_front(), rdata);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(61815));
        repeat (4) @(posedge clk);
        reset_n <= 1;
        rd(OFS_CTRL_ONE, RESET_VALUE);
        rd(OFS_CTRL_TWO, RESET_VALUE);
        rd(OFS_EVENT_STATUS, RESET_VALUE);
        for (int i = 0; i < 4; i++) begin
            d = ($urandom & C1_WRITE_MASK & ~32'h0003_0018) | (32'(i) << C1_DMA_LO);
            if (i == 3) d[7:6] = 2'b11;
            inserted <= i[0];
            wr(OFS_CTRL_ONE, d);
            idle(8);
            check_port("ctrl one levels", {d[26:24], d[19:18], d[8], d[2:1]},
                {wake_on_removal, wake_on_insertion, wake_on_card_irq, irq_at_block_gap,
                 read_wait_ctrl, card_bus_power, high_speed_enable, data_bus_width});
            check_port("card present", d[7] ? d[6] : i[0], card_present);
            check_port("dma v2", i == 2, descriptor_dma_v2);
            rd(OFS_CTRL_ONE, d);
        end
        wr(OFS_CTRL_ONE, 32'h0002_0000);
        #1 check_port("continue pulse", 1, continue_request);
        wr(OFS_CTRL_ONE, 32'h0001_0000);
        idle(2);
        check_port("stop request", 1, stop_at_gap_request);
        wr(OFS_CTRL_ONE, 32'h0003_0000);
        #1 check_port("continue blocked", 0, continue_request);
        // Internal clock first, divider only while the card clock is off
        wr(OFS_CTRL_TWO, 32'h0000_0001);
        idle(12);
        rd(OFS_CTRL_TWO, 32'h0000_0003);
        for (int i = 0; i < 9; i++) begin
            d = {12'h0, 4'(i == 8 ? 15 : i), (i == 0) ? 8'h00 : 8'(1 << (i - 1)), 8'h01};
            wr(OFS_CTRL_TWO, d);
            wr(OFS_CTRL_TWO, d | 32'h4);
            idle(10);
            check_port("timeout exponent", 13 + d[19:16], timeout_exponent);
            r0 = rises;
            idle(1024);
            check_port("card clock rises", (i == 0) ? 512 : 512 >> (i - 1), rises - r0);
        end
        wr(OFS_CTRL_TWO, 32'h0000_0101);
        idle(4);
        r0 = rises;
        idle(64);
        check_port("card clock off", 0, rises - r0);
        @(posedge clk);
        error_set <= 10'($urandom);
        event_set <= 16'($urandom);
        @(posedge clk);
        st = {6'h0, error_set, |event_set[8:0], 6'h0, event_set[8:0]};
        error_set <= '0;
        event_set <= '0;
        rd(OFS_EVENT_STATUS, st);
        d = $urandom & ST_FLAG_MASK;
        wr(OFS_EVENT_STATUS, d);
        st = st & ~d;
        st[15] = |st[9:0];
        rd(OFS_EVENT_STATUS, st);
        wr(OFS_EVENT_STATUS, '0);
        rd(OFS_EVENT_STATUS, st);
        wr(OFS_CTRL_TWO, 32'h0200_0001);
        idle(3);
        rd(OFS_EVENT_STATUS, '0);
        wr(OFS_CTRL_TWO, 32'h0400_0001);
        wr(OFS_CTRL_TWO, 32'h0100_0000);
        idle(3);
        rd(OFS_CTRL_ONE, '0);
        rd(OFS_CTRL_TWO, '0);
        idle(2);
        complete_run();
    end
endmodule

/* File: sdhc_regs_pkg.sv */
// Purpose: Constants for the card host control and event flag register bank
// Assumes: Plain register port, 32-bit data, word-aligned byte addresses
// Notes:   Offsets are local choices; bit positions follow the register layout
package sdhc_regs_pkg;
    localparam int          ADDR_W            = 8;
    localparam logic [7:0]  OFS_CTRL_ONE      = 8'h00;
    localparam logic [7:0]  OFS_CTRL_TWO      = 8'h04;
    localparam logic [7:0]  OFS_EVENT_STATUS  = 8'h08;
    // Control one field positions
    localparam int          C1_WAKE_REM       = 26;
    localparam int          C1_WAKE_INS       = 25;
    localparam int          C1_WAKE_IRQ       = 24;
    localparam int          C1_IRQ_GAP        = 19;
    localparam int          C1_READ_WAIT      = 18;
    localparam int          C1_CONTINUE       = 17;
    localparam int          C1_STOP_GAP       = 16;
    localparam int          C1_BUS_POWER      = 8;
    localparam int          C1_CD_SEL         = 7;
    localparam int          C1_CD_TEST        = 6;
    localparam int          C1_DMA_LO         = 3;
    localparam int          C1_HIGH_SPEED     = 2;
    localparam int          C1_BUS_WIDTH      = 1;
    localparam logic [31:0] C1_WRITE_MASK     = 32'h070f_01de;
    localparam logic [1:0]  DMA_MODE_DESCRIPTOR_DMA_V2    = 2'h2;
    // Control two field positions
    localparam int          C2_RST_DATA       = 26;
    localparam int          C2_RST_CMD        = 25;
    localparam int          C2_RST_ALL        = 24;
    localparam int          C2_TIMEOUT_LO     = 16;
    localparam int          C2_DIV_LO         = 8;
    localparam int          C2_CARD_CLK_EN    = 2;
    localparam int          C2_CLK_STABLE     = 1;
    localparam int          C2_INT_CLK_EN     = 0;
    localparam logic [31:0] C2_WRITE_MASK     = 32'h070f_ff05;
    localparam int          TIMEOUT_BASE_EXP  = 13;
    // Event status layout
    localparam int          ST_SUMMARY        = 15;
    localparam logic [31:0] ST_FLAG_MASK      = 32'h03ff_01ff;
    localparam logic [31:0] ST_SUMMARY_SRC    = 32'h0000_03ff;
    localparam logic [31:0] RESET_VALUE       = 32'h0000_0000;
    // Internal clock settle time
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          CLK_SETTLE_NS     = 100;
    localparam int          CLK_SETTLE_CYC    = (CLK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  SETTLE_CNT_INIT   = 8'(CLK_SETTLE_CYC);
    // Pin synchroniser depth
    localparam int          SYNC_STAGES       = 3;
endpackage
